// File: core/pgc_power_good_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Half bit picks 0.32/0.64 ms steps, else 0.5/1 ms, by doubling bit.
// - Request pulls interrupt low; merge bit also pulls it low when rail 0 not good.
// - Debounce only toward valid: short when select 0, 11 ms when 1.
// - Latched bit 0: output shows live status of monitored rails.
// - Latched bit 1: output inactive while any rail fault flag is set.
// - Window bit 0 checks undervoltage only; 1 checks both limits.
// - Output type bit: 0 push-pull on analog supply, 1 open-drain.
// - Polarity bit 0: high when valid; 1: low when valid.
// - Fault flag sets on rail invalid; fault read clears it only if valid.
// - Source select: 0 excluded, 1 voltage, 3 voltage and current limit.
module pgc_power_good_ctrl #(
  parameter int RAILS = 4,
  parameter int STEP_FULL_CYC = pgc_pkg::STEP_FULL_CYC,
  parameter int STEP_DOUBLE_CYC = pgc_pkg::STEP_DOUBLE_CYC,
  parameter int STEP_HALF_CYC = pgc_pkg::STEP_HALF_CYC,
  parameter int STEP_HALF_DOUBLE_CYC = pgc_pkg::STEP_HALF_DOUBLE_CYC,
  parameter int DEBOUNCE_LONG_CYC = pgc_pkg::DEBOUNCE_LONG_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Register port from the serial host engine
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Rail monitors, asynchronous
  input wire logic [RAILS-1:0] rail_uv_ok_in,
  input wire logic [RAILS-1:0] rail_ov_ok_in,
  input wire logic [RAILS-1:0] rail_ilim_in,
  // Same-clock inputs
  input wire logic irq_req_in,
  input wire logic double_delay_in,
  // Outputs
  output logic delay_tick_out,
  output logic irq_out_n,
  output logic power_good_out,
  output logic power_good_oe_out
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [3*RAILS-1:0] sync1_reg;
  logic [3*RAILS-1:0] sync2_reg;
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {rail_ilim_in, rail_ov_ok_in, rail_uv_ok_in};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] src_sel_reg;
  logic [7:0] src_sel_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [3:0] fault_rsvd_reg;
  logic [3:0] fault_rsvd_next;
  logic [RAILS-1:0] rail_fault_flag_reg;
  logic [RAILS-1:0] rail_fault_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [RAILS-1:0] rail_valid;
  logic all_valid;

  // Per-rail validity
  genvar g;
  generate
    for (g = 0; g < RAILS; g++)
    begin : g_rail
      logic volt_ok;
      assign volt_ok = sync2_reg[g] & (~ctrl_reg[pgc_pkg::WINDOW_BIT] | sync2_reg[RAILS+g]);
      assign rail_valid[g] = (src_sel_reg[2*g+:2] == pgc_pkg::SRC_MASKED) ? 1'b1 :
                             (src_sel_reg[2*g+:2] == pgc_pkg::SRC_VOLT_ILIM) ? (volt_ok & ~sync2_reg[2*RAILS+g]) :
                             volt_ok;
    end
  endgenerate
  assign all_valid = &rail_valid;

  always_comb
  begin
    src_sel_next = src_sel_reg;
    ctrl_next = ctrl_reg;
    fault_rsvd_next = fault_rsvd_reg;
    rail_fault_flag_next = rail_fault_flag_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_wr_in)
    begin
      if (reg_addr_in == pgc_pkg::SRC_SEL_ADDR)
        src_sel_next = reg_wdata_in;
      if (reg_addr_in == pgc_pkg::CTRL_TWO_ADDR)
        ctrl_next = reg_wdata_in;
      if (reg_addr_in == pgc_pkg::FAULT_ADDR)
        fault_rsvd_next = reg_wdata_in[7:4];
    end
    if (reg_rd_in)
    begin
      rvalid_next = 1'b1;
      unique case (reg_addr_in)
        pgc_pkg::SRC_SEL_ADDR: rdata_next = src_sel_reg;
        pgc_pkg::CTRL_TWO_ADDR: rdata_next = ctrl_reg;
        pgc_pkg::FAULT_ADDR: rdata_next = {fault_rsvd_reg, 4'(rail_fault_flag_reg)};
        default: rdata_next = 8'h00;
      endcase
      if (reg_addr_in == pgc_pkg::FAULT_ADDR)
        rail_fault_flag_next = rail_fault_flag_reg & ~rail_valid;
    end
    rail_fault_flag_next = rail_fault_flag_next | ~rail_valid;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      src_sel_reg <= pgc_pkg::SRC_SEL_RESET;
      ctrl_reg <= pgc_pkg::CTRL_TWO_RESET;
      fault_rsvd_reg <= pgc_pkg::FAULT_RSVD_RESET;
      rail_fault_flag_reg <= '0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      src_sel_reg <= src_sel_next;
      ctrl_reg <= ctrl_next;
      fault_rsvd_reg <= fault_rsvd_next;
      rail_fault_flag_reg <= rail_fault_flag_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------
  // Delay step divider
  // ----------------------------------------
  logic [15:0] step_cnt_reg;
  logic [15:0] step_cnt_next;
  logic [15:0] step_len;
  logic tick_reg;
  logic tick_next;
  always_comb
  begin
    unique case ({ctrl_reg[pgc_pkg::HALF_DELAY_BIT], double_delay_in})
      2'b00: step_len = 16'(STEP_FULL_CYC);
      2'b01: step_len = 16'(STEP_DOUBLE_CYC);
      2'b10: step_len = 16'(STEP_HALF_CYC);
      2'b11: step_len = 16'(STEP_HALF_DOUBLE_CYC);
    endcase
    tick_next = 1'b0;
    step_cnt_next = step_cnt_reg + 16'h0001;
    if (step_cnt_reg >= step_len - 16'h0001)
    begin
      tick_next = 1'b1;
      step_cnt_next = 16'h0000;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      step_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      step_cnt_reg <= step_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // ----------------------------------------
  // Debounce and pin drive
  // ----------------------------------------
  // Wide enough for the long debounce; going invalid is never delayed
  logic [23:0] deb_cnt_reg;
  logic [23:0] deb_cnt_next;
  logic live_good_reg;
  logic live_good_next;
  logic [23:0] deb_len;
  logic good;
  logic level;
  logic pg_reg;
  logic pg_next;
  logic pg_oe_reg;
  logic pg_oe_next;
  logic irq_n_reg;
  logic irq_n_next;
  always_comb
  begin
    deb_len = ctrl_reg[pgc_pkg::DEBOUNCE_BIT] ? 24'(DEBOUNCE_LONG_CYC) : 24'(pgc_pkg::DEBOUNCE_SHORT_CYC);
    deb_cnt_next = 24'h000000;
    live_good_next = 1'b0;
    if (all_valid)
    begin
      if (live_good_reg || deb_cnt_reg >= deb_len - 24'h000001)
        live_good_next = 1'b1;
      else
        deb_cnt_next = deb_cnt_reg + 24'h000001;
    end
    good = ctrl_reg[pgc_pkg::LATCHED_BIT] ? ~|rail_fault_flag_reg : live_good_reg;
    level = good ^ ctrl_reg[pgc_pkg::POLARITY_BIT];
    pg_next = ctrl_reg[pgc_pkg::OPEN_DRAIN_BIT] ? 1'b0 : level;
    pg_oe_next = ctrl_reg[pgc_pkg::OPEN_DRAIN_BIT] ? ~level : 1'b1;
    irq_n_next = ~(irq_req_in | (ctrl_reg[pgc_pkg::MERGE_BIT] & ~rail_valid[0]));
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      deb_cnt_reg <= 24'h000000;
      live_good_reg <= 1'b0;
      pg_reg <= 1'b0;
      pg_oe_reg <= 1'b1;
      irq_n_reg <= 1'b1;
    end
    else
    begin
      deb_cnt_reg <= deb_cnt_next;
      live_good_reg <= live_good_next;
      pg_reg <= pg_next;
      pg_oe_reg <= pg_oe_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign delay_tick_out = tick_reg;
  assign irq_out_n = irq_n_reg;
  assign power_good_out = pg_reg;
  assign power_good_oe_out = pg_oe_reg;
endmodule

// File: inc/pgc_pkg.sv
package pgc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] SRC_SEL_ADDR = 8'h28;
  localparam logic [7:0] CTRL_TWO_ADDR = 8'h29;
  localparam logic [7:0] FAULT_ADDR = 8'h2A;
  localparam logic [7:0] SRC_SEL_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [3:0] FAULT_RESET = 4'h0;
  localparam logic [3:0] FAULT_RSVD_RESET = 4'h0;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int HALF_DELAY_BIT = 7;
  localparam int MERGE_BIT = 6;
  localparam int DEBOUNCE_BIT = 5;
  localparam int LATCHED_BIT = 4;
  localparam int RSVD_BIT = 3;
  localparam int WINDOW_BIT = 2;
  localparam int OPEN_DRAIN_BIT = 1;
  localparam int POLARITY_BIT = 0;

  // ----------------------------------------
  // Source select codes
  // ----------------------------------------
  localparam logic [1:0] SRC_MASKED = 2'h0;
  localparam logic [1:0] SRC_VOLT = 2'h1;
  localparam logic [1:0] SRC_RSVD = 2'h2;
  localparam logic [1:0] SRC_VOLT_ILIM = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 20000;
  localparam int STEP_FULL_US = 500;
  localparam int STEP_DOUBLE_US = 1000;
  localparam int STEP_HALF_US = 320;
  localparam int STEP_HALF_DOUBLE_US = 640;
  localparam int DEBOUNCE_SHORT_NS = 5000;
  localparam int DEBOUNCE_LONG_US = 11000;
  localparam int STEP_FULL_CYC = STEP_FULL_US * CLK_KHZ / 1000;
  localparam int STEP_DOUBLE_CYC = STEP_DOUBLE_US * CLK_KHZ / 1000;
  localparam int STEP_HALF_CYC = STEP_HALF_US * CLK_KHZ / 1000;
  localparam int STEP_HALF_DOUBLE_CYC = STEP_HALF_DOUBLE_US * CLK_KHZ / 1000;
  localparam int DEBOUNCE_SHORT_CYC = (DEBOUNCE_SHORT_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int DEBOUNCE_LONG_CYC = DEBOUNCE_LONG_US * CLK_KHZ / 1000;
endpackage

// File: tb/pgc_pin_model.sv
`timescale 1ns/1ps
// ----------------------------
// Supervisor side of the pin
// ----------------------------
module pgc_pin_model (
  // Drive from the block
  input wire logic pg_drive_in,
  input wire logic pg_oe_in,
  // Level seen by supervisor
  output logic pin_level_out
);
  assign pin_level_out = pg_oe_in ? pg_drive_in : 1'b1;
endmodule

// File: tb/pgc_properties.sv
`timescale 1ns/1ps
// ----------------------------
// Power-good control checker
// ----------------------------
module pgc_properties #(
  parameter int STEP_FULL_CYC = 10,
  parameter int STEP_DOUBLE_CYC = 20,
  parameter int STEP_HALF_CYC = 6,
  parameter int STEP_HALF_DOUBLE_CYC = 12,
  parameter int DEBOUNCE_LONG_CYC = 50
) (
  // Clock, reset, register port
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Rails and outputs
  input wire logic [3:0] rail_uv_ok_in,
  input wire logic irq_req_in,
  input wire logic double_delay_in,
  input wire logic delay_tick_out,
  input wire logic irq_out_n,
  input wire logic power_good_out
);
  logic [7:0] ctrl_q, src_q;
  logic [3:0] used;
  logic bad, chg;
  int vcnt, gcnt, step, step_q;
  // Undervoltage only: a weaker but never false view of validity
  assign used = {|src_q[7:6], |src_q[5:4], |src_q[3:2], |src_q[1:0]};
  assign bad = |(~rail_uv_ok_in & used);
  assign step = ctrl_q[pgc_pkg::HALF_DELAY_BIT] ? (double_delay_in ? STEP_HALF_DOUBLE_CYC : STEP_HALF_CYC)
    : (double_delay_in ? STEP_DOUBLE_CYC : STEP_FULL_CYC);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ctrl_q <= 8'h00;
      src_q <= 8'h00;
      vcnt <= 0;
      chg <= 1'b1;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == pgc_pkg::CTRL_TWO_ADDR)
        ctrl_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == pgc_pkg::SRC_SEL_ADDR)
        src_q <= reg_wdata_in;
      vcnt <= bad ? 0 : vcnt + 1;
      // Step change spoils the interval it falls in
      chg <= step != step_q || (chg && !delay_tick_out);
    end
    gcnt <= delay_tick_out ? 1 : gcnt + 1;
    step_q <= step;
  end
  irq_req_a:
  assert property (irq_req_in |=> !irq_out_n) else $error("irq not low on request");
  no_merge_a:
  assert property ((!ctrl_q[6] && !irq_req_in) [*2] |-> irq_out_n) else $error("irq low without cause");
  merge_rail_a:
  assert property ((ctrl_q[6] && used[0] && !rail_uv_ok_in[0] && $stable(ctrl_q)) [*4] |-> !irq_out_n)
    else $error("rail0 not merged");
  bad_level_a:
  assert property ((!ctrl_q[1] && bad && $stable(ctrl_q)) [*5] |-> power_good_out == ctrl_q[0])
    else $error("good level wrong");
  debounce_len_a:
  assert property ($rose(power_good_out) && ctrl_q[4:0] == 5'h00 |->
    vcnt >= (ctrl_q[pgc_pkg::DEBOUNCE_BIT] ? DEBOUNCE_LONG_CYC : pgc_pkg::DEBOUNCE_SHORT_CYC))
    else $error("debounce short");
  tick_step_a:
  assert property (delay_tick_out && !chg && step == step_q |-> gcnt == step) else $error("step wrong");
  ctrl_read_a:
  assert property (reg_rd_in && reg_addr_in == pgc_pkg::CTRL_TWO_ADDR |=> reg_rdata_out == $past(ctrl_q))
    else $error("control readback wrong");
  open_drain_a:
  assert property ((ctrl_q[1] && $stable(ctrl_q)) [*2] |-> !power_good_out) else $error("drain drives high");
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
  logic core_clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_req_in = 1'b0;
  logic double_delay_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [3:0] rail_uv_ok_in = 4'h0, rail_ov_ok_in = 4'hF, rail_ilim_in = 4'h0;
  logic reg_rvalid_out, delay_tick_out, irq_out_n, power_good_out, power_good_oe_out, pin_level;
  int err_total = 0, checked = 0, cycles = 0, n;
  int steps[4] = '{10, 20, 6, 12};
  pgc_power_good_ctrl #(.STEP_FULL_CYC(10), .STEP_DOUBLE_CYC(20), .STEP_HALF_CYC(6),
    .STEP_HALF_DOUBLE_CYC(12), .DEBOUNCE_LONG_CYC(150)) dut_u (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .rail_uv_ok_in(rail_uv_ok_in),
    .rail_ov_ok_in(rail_ov_ok_in),
    .rail_ilim_in(rail_ilim_in),
    .irq_req_in(irq_req_in),
    .double_delay_in(double_delay_in),
    .delay_tick_out(delay_tick_out),
    .irq_out_n(irq_out_n),
    .power_good_out(power_good_out),
    .power_good_oe_out(power_good_oe_out)
  );
  pgc_pin_model pin_u (.pg_drive_in(power_good_out), .pg_oe_in(power_good_oe_out), .pin_level_out(pin_level));
  always #25 core_clk_in = ~core_clk_in;
  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, run needs about 710 cycles
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    cyc(1);
    reg_wr_in <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    cyc(1);
    reg_rd_in <= 1'b0;
    cyc(1);
    `CHK("rdata", e, reg_rdata_out)
    `CHK("rvalid", 1'b1, reg_rvalid_out)
  endtask
  task automatic gap();
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (delay_tick_out !== 1'b1 && n < 50);
  endtask
  initial
  begin
    cyc(8);
    srst_in <= 1'b0;
    cyc(1);
    rd(8'h29, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h29, 8'h08);
    rd(8'h29, 8'h08);
    cyc(85);
    `CHK("pg", 1'b0, power_good_out)
    cyc(20);
    `CHK("pg", 1'b1, power_good_out)
    wr(8'h29, 8'h01);
    cyc(3);
    `CHK("pg", 1'b0, power_good_out)
    `CHK("oe", 1'b1, power_good_oe_out)
    wr(8'h29, 8'h02);
    cyc(3);
    `CHK("oe", 1'b0, power_good_oe_out)
    `CHK("pin", 1'b1, pin_level)
    wr(8'h28, 8'h75);
    wr(8'h29, 8'h00);
    cyc(6);
    `CHK("pg", 1'b0, power_good_out)
    rail_uv_ok_in <= 4'hF;
    rail_ilim_in <= 4'h4;
    cyc(120);
    `CHK("pg", 1'b0, power_good_out)
    rail_ilim_in <= 4'h0;
    cyc(120);
    `CHK("pg", 1'b1, power_good_out)
    rail_ov_ok_in <= 4'h2;
    cyc(10);
    `CHK("pg", 1'b1, power_good_out)
    wr(8'h29, 8'h04);
    cyc(6);
    `CHK("pg", 1'b0, power_good_out)
    rail_ov_ok_in <= 4'hF;
    wr(8'h29, 8'h10);
    cyc(6);
    `CHK("pg", 1'b0, power_good_out)
    rd(8'h2A, 8'h0F);
    cyc(3);
    `CHK("pg", 1'b1, power_good_out)
    rail_uv_ok_in <= 4'h7;
    cyc(5);
    `CHK("pg", 1'b0, power_good_out)
    rd(8'h2A, 8'h08);
    rd(8'h2A, 8'h08);
    rail_uv_ok_in <= 4'hF;
    cyc(4);
    rd(8'h2A, 8'h08);
    rd(8'h2A, 8'h00);
    wr(8'h29, 8'h40);
    rail_uv_ok_in <= 4'hE;
    cyc(5);
    `CHK("irq", 1'b0, irq_out_n)
    wr(8'h29, 8'h00);
    cyc(3);
    `CHK("irq", 1'b1, irq_out_n)
    irq_req_in <= 1'b1;
    cyc(2);
    `CHK("irq", 1'b0, irq_out_n)
    irq_req_in <= 1'b0;
    rail_uv_ok_in <= 4'hF;
    wr(8'h29, 8'h20);
    cyc(130);
    `CHK("pg", 1'b0, power_good_out)
    cyc(30);
    `CHK("pg", 1'b1, power_good_out)
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h29, {i[1], 7'h00});
      double_delay_in <= i[0];
      gap();
      gap();
      `CHK("step", steps[i], n)
    end
    tally_and_finish();
  end
endmodule
bind pgc_power_good_ctrl pgc_properties #(.STEP_FULL_CYC(STEP_FULL_CYC), .STEP_DOUBLE_CYC(STEP_DOUBLE_CYC),
  .STEP_HALF_CYC(STEP_HALF_CYC), .STEP_HALF_DOUBLE_CYC(STEP_HALF_DOUBLE_CYC),
  .DEBOUNCE_LONG_CYC(DEBOUNCE_LONG_CYC)) chk_u (
  .core_clk_in(core_clk_in),
  .srst_in(srst_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .rail_uv_ok_in(rail_uv_ok_in),
  .irq_req_in(irq_req_in),
  .double_delay_in(double_delay_in),
  .delay_tick_out(delay_tick_out),
  .irq_out_n(irq_out_n),
  .power_good_out(power_good_out)
);
